// ### bus_address_selector.sv
// Programmable bus address selector, top level
//
// What this block does
// - Range is power-of-two bytes, 1 to 4G
// - Match values loaded at init, then fixed
// - Alignment setting plus size decode lanes
// - Decode one flat 32-bit address space
// - One of three functions per selector
// - Split mode: read and write decode outputs
// - Chip mode: select any, read shows direction
// - DMA mode: relocatable enable, steer handshakes
// - Two read, two write lane enables
// - Word write asserts all lane enables
// - Half-word write replicated on both halves
// - Byte write replicated on four lanes
// - Partial write enables written lanes only
// - Master captures read data next edge
// - Low/high masks; both set is don't-care
// - Decode lands one edge after the address
// - Unselected drive zero; reads are OR-ed
`timescale 1ns/1ps

module bus_address_selector
    import selector_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              cfg_load,
    input  wire logic [ADDR_W-1:0] cfg_low_match_mask,
    input  wire logic [ADDR_W-1:0] cfg_high_match_mask,
    input  wire logic [1:0]        cfg_align,
    input  wire logic [1:0]        cfg_function,
    input  wire logic              cfg_lane_base,
    input  wire logic              bus_valid,
    input  wire logic              bus_write,
    input  wire logic [1:0]        bus_size,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic [DATA_W-1:0] bus_wdata,
    input  wire logic [DATA_W-1:0] user_rdata,
    input  wire logic              user_dma_req,
    input  wire logic              user_early_stop,
    input  wire logic [DMA_CHANNELS-1:0] dma_ack_in,
    input  wire logic [DMA_CHANNELS-1:0] dma_early_ack_in,
    output logic      [1:0]        read_decode_out,
    output logic      [1:0]        write_decode_out,
    output logic      [1:0]        chip_select_out,
    output logic      [DATA_W-1:0] wdata_out,
    output logic      [DATA_W-1:0] rdata_out,
    output logic [DMA_CHANNELS-1:0] dma_request_steer,
    output logic      [DMA_CHANNELS-1:0] early_stop_request,
    output logic                   dma_ack_steer,
    output logic                   early_stop_ack,
    output logic                   cfg_loaded
);

    // ------------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------------
    load_state_type    state_ff;       // Loaded or not
    load_state_type    nxt_state;
    logic [ADDR_W-1:0] low_match_mask_ff;   // Bits matching when low
    logic [ADDR_W-1:0] nxt_low_match_mask;
    logic [ADDR_W-1:0] high_match_mask_ff;  // Bits matching when high
    logic [ADDR_W-1:0] nxt_high_match_mask;
    logic [1:0]        align_ff;       // Configured access width
    logic [1:0]        nxt_align;
    logic [1:0]        func_ff;        // Configured function
    logic [1:0]        nxt_func;
    logic              lane_base_ff;   // Upper or lower lane pair
    logic              nxt_lane_base;

    // Configuration is taken once; later load strobes are ignored
    always_comb begin
        nxt_state           = state_ff;
        nxt_low_match_mask  = low_match_mask_ff;
        nxt_high_match_mask = high_match_mask_ff;
        nxt_align           = align_ff;
        nxt_func            = func_ff;
        nxt_lane_base       = lane_base_ff;
        if (state_ff == ST_UNLOADED && cfg_load) begin
            nxt_state           = ST_LOADED;
            nxt_low_match_mask  = cfg_low_match_mask;
            nxt_high_match_mask = cfg_high_match_mask;
            nxt_align           = cfg_align;
            nxt_func            = cfg_function;
            nxt_lane_base       = cfg_lane_base;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff           <= ST_UNLOADED;
            low_match_mask_ff  <= MASK_RST;
            high_match_mask_ff <= MASK_RST;
            align_ff           <= ALIGN_WORD;
            func_ff            <= FUNC_SPLIT;
            lane_base_ff       <= 1'b0;
        end else begin
            state_ff           <= nxt_state;
            low_match_mask_ff  <= nxt_low_match_mask;
            high_match_mask_ff <= nxt_high_match_mask;
            align_ff           <= nxt_align;
            func_ff            <= nxt_func;
            lane_base_ff       <= nxt_lane_base;
        end
    end

    // ------------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] bit_ok;   // Per-bit match
    logic              addr_hit; // Whole address matches

    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_bit
            assign bit_ok[gi] = bus_addr[gi] ? high_match_mask_ff[gi]
                                             : low_match_mask_ff[gi];
        end
    endgenerate

    // contiguous don't-care low bits give power-of-two ranges
    assign addr_hit = &bit_ok;

    // ------------------------------------------------------------------
    // Lane decode
    // ------------------------------------------------------------------
    logic [1:0] lane_hit;   // two lanes per selector

    lane_decode u_lane (
        .align     (align_ff),
        .size      (bus_size),
        .addr_lo   (bus_addr[1:0]),
        .lane_base (lane_base_ff),
        .lane_hit  (lane_hit)
    );

    // ------------------------------------------------------------------
    // Output decode and DMA control word
    // ------------------------------------------------------------------
    logic [1:0]  rd_ff, nxt_rd;         // Read decode
    logic [1:0]  wr_ff, nxt_wr;         // Write decode
    logic [1:0]  cs_ff, nxt_cs;         // Chip select
    logic [DATA_W-1:0] wd_ff, nxt_wd;   // Replicated write data
    logic [DATA_W-1:0] rdd_ff, nxt_rdd; // Captured read data
    logic        dma_en_ff, nxt_dma_en; // DMA requests enabled
    logic [DMA_CH_W-1:0] dma_ch_ff, nxt_dma_ch; // Chosen channel
    logic [DMA_CHANNELS-1:0] req_ff, nxt_req;   // Steered request
    logic [DMA_CHANNELS-1:0] est_ff, nxt_est;   // Steered early stop
    logic        ack_ff, nxt_ack;       // Returned acknowledge
    logic        eack_ff, nxt_eack;     // Returned early ack
    logic        hit;                   // Valid matched transfer
    logic [1:0]  lane_rd, lane_wr;      // Lane enables by direction

    // Outputs are registered, so decode lands one edge after the
    // address; this is the cost of every output coming from a flop
    always_comb begin
        hit     = bus_valid && addr_hit && (state_ff == ST_LOADED);
        lane_rd = (hit && !bus_write) ? lane_hit : 2'h0;
        lane_wr = (hit &&  bus_write) ? lane_hit : 2'h0;
        nxt_rd  = 2'h0;
        nxt_wr  = 2'h0;
        nxt_cs  = 2'h0;
        nxt_dma_en = dma_en_ff;
        nxt_dma_ch = dma_ch_ff;
        case (func_ff)
            FUNC_SPLIT: begin
                nxt_rd = lane_rd;
                nxt_wr = lane_wr;
            end
            FUNC_CHIP: begin
                nxt_cs = lane_rd | lane_wr;
                nxt_rd = lane_rd;
            end
            FUNC_DMA: begin
                if (lane_wr[0]) begin
                    nxt_dma_en = bus_wdata[DMA_EN_BIT];
                    nxt_dma_ch = bus_wdata[DMA_CH_LSB +: DMA_CH_W];
                end
                nxt_rd = lane_rd;
            end
            default: begin
                nxt_rd = 2'h0;
            end
        endcase
        case (bus_size)
            SIZE_BYTE: nxt_wd = {LANES{bus_wdata[7:0]}};
            SIZE_HALF: nxt_wd = {2{bus_wdata[15:0]}};
            default:   nxt_wd = bus_wdata;
        endcase
        // OR-merged read data taken next edge
        nxt_rdd = user_rdata;
        // steer handshakes to and from chosen channel
        nxt_req  = '0;
        nxt_est  = '0;
        if (func_ff == FUNC_DMA && dma_en_ff) begin
            nxt_req[dma_ch_ff] = user_dma_req;
            nxt_est[dma_ch_ff] = user_early_stop;
        end
        nxt_ack  = (func_ff == FUNC_DMA) && dma_ack_in[dma_ch_ff];
        nxt_eack = (func_ff == FUNC_DMA) && dma_early_ack_in[dma_ch_ff];
    end

    // Output registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_ff     <= LANE_RST;
            wr_ff     <= LANE_RST;
            cs_ff     <= LANE_RST;
            wd_ff     <= '0;
            rdd_ff    <= '0;
            dma_en_ff <= 1'b0;
            dma_ch_ff <= DMA_CH_RST;
            req_ff    <= '0;
            est_ff    <= '0;
            ack_ff    <= 1'b0;
            eack_ff   <= 1'b0;
        end else begin
            rd_ff     <= nxt_rd;
            wr_ff     <= nxt_wr;
            cs_ff     <= nxt_cs;
            wd_ff     <= nxt_wd;
            rdd_ff    <= nxt_rdd;
            dma_en_ff <= nxt_dma_en;
            dma_ch_ff <= nxt_dma_ch;
            req_ff    <= nxt_req;
            est_ff    <= nxt_est;
            ack_ff    <= nxt_ack;
            eack_ff   <= nxt_eack;
        end
    end

    assign read_decode_out    = rd_ff;
    assign write_decode_out   = wr_ff;
    assign chip_select_out    = cs_ff;
    assign wdata_out          = wd_ff;
    assign rdata_out          = rdd_ff;
    assign dma_request_steer  = req_ff;
    assign early_stop_request = est_ff;
    assign dma_ack_steer      = ack_ff;
    assign early_stop_ack     = eack_ff;
    assign cfg_loaded         = (state_ff == ST_LOADED);

endmodule

// ### bus_address_selector_bench.sv
// Self-checking bench for the bus address selector
`timescale 1ns/1ps

module bus_address_selector_bench;
    import selector_pkg::*;

    // ----------
    // Design ports
    // ----------
    logic        mclk = 1'b0, resetn = 1'b0, cfg_load = 1'b0;
    logic        cfg_lane_base = 1'b0, bus_valid = 1'b0, bus_write = 1'b0;
    logic        user_dma_req = 1'b0, user_early_stop = 1'b0;
    logic [1:0]  cfg_align = 2'h0, cfg_function = 2'h0, bus_size = 2'h0;
    logic [31:0] cfg_low_match_mask = '0, cfg_high_match_mask = '0;
    logic [31:0] bus_addr = '0, bus_wdata = '0, user_rdata;
    logic [3:0]  dma_ack_in = 4'h0, dma_early_ack_in = 4'h0;
    logic [1:0]  read_decode_out, write_decode_out, chip_select_out;
    logic [31:0] wdata_out, rdata_out;
    logic [3:0]  dma_request_steer, early_stop_request;
    logic        dma_ack_steer, early_stop_ack, cfg_loaded;

    // Reference model state and expectations
    logic [31:0] m_low, m_high, e_wd, e_rd32, base, msk;
    logic [1:0]  m_al, m_fn, m_ch = 2'h0, e_rd, e_wr, e_cs;
    logic [3:0]  e_req, e_esr;
    logic        m_lb, m_ld = 1'b0, m_en = 1'b0, e_ack, e_eack, e_ld;
    logic        wchk;
    int          err_total = 0, comparisons = 0;

    bus_address_selector i_bus_address_selector (.*);
    user_register_model i_user_register_model (.*);

    initial forever #50 mclk = ~mclk;

    // ----------
    // Reference model, evaluated on pre-edge inputs
    // ----------
    always @(posedge mclk) begin : model
        logic [3:0] l4;
        logic [1:0] s2;
        logic       hit;
        if (!resetn) {m_ld, m_en, m_ch} = 4'h0;
        hit = bus_valid && m_ld && bus_size != 2'h3 && bus_size >= m_al &&
              &((~bus_addr & m_low) | (bus_addr & m_high));
        l4 = bus_size == SIZE_WORD ? 4'hf : bus_size == SIZE_HALF ?
             (bus_addr[1] ? 4'hc : 4'h3) : 4'h1 << bus_addr[1:0];
        s2 = !hit ? 2'h0 : m_lb ? l4[3:2] : l4[1:0];
        e_rd = bus_write ? 2'h0 : s2;
        e_wr = bus_write && m_fn == FUNC_SPLIT ? s2 : 2'h0;
        e_cs = m_fn == FUNC_CHIP ? s2 : 2'h0;
        wchk = bus_write && s2 != 2'h0;
        e_wd = bus_size == SIZE_BYTE ? {4{bus_wdata[7:0]}} :
               bus_size == SIZE_HALF ? {2{bus_wdata[15:0]}} : bus_wdata;
        e_rd32 = resetn ? user_rdata : 32'h0;
        e_req = m_en ? 4'(user_dma_req) << m_ch : 4'h0;
        e_esr = m_en ? 4'(user_early_stop) << m_ch : 4'h0;
        // Acknowledges return whenever the DMA function is loaded
        e_ack = m_ld && m_fn == FUNC_DMA && dma_ack_in[m_ch];
        e_eack = m_ld && m_fn == FUNC_DMA && dma_early_ack_in[m_ch];
        // Control word write; steering follows from the next edge
        if (hit && bus_write && m_fn == FUNC_DMA && s2[0]) begin
            m_en = bus_wdata[DMA_EN_BIT];
            m_ch = bus_wdata[DMA_CH_LSB +: DMA_CH_W];
        end
        if (resetn && cfg_load && !m_ld) begin
            {m_ld, m_low} = {1'b1, cfg_low_match_mask};
            m_high = cfg_high_match_mask;
            {m_al, m_fn, m_lb} = {cfg_align, cfg_function, cfg_lane_base};
        end
        e_ld = m_ld;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Compare away from the active edge
    always @(negedge mclk) begin
        check(read_decode_out, e_rd);
        check(write_decode_out, e_wr);
        check(chip_select_out, e_cs);
        if (wchk) check(wdata_out, e_wd);
        check(rdata_out, e_rd32);
        check(cfg_loaded, e_ld);
        check(dma_request_steer, e_req);
        check(early_stop_request, e_esr);
        check(dma_ack_steer, e_ack);
        check(early_stop_ack, e_eack);
    end

    // One random bus cycle; after load the load strobe and low mask churn too
    task automatic step(input bit post);
        @(posedge mclk);
        bus_valid <= $urandom_range(3) != 0;
        bus_write <= 1'($urandom);
        bus_size <= 2'($urandom);
        bus_addr <= $urandom_range(3) != 0 ? base | ($urandom & msk)
                                           : $urandom;
        bus_wdata <= $urandom;
        {user_dma_req, user_early_stop} <= 2'($urandom);
        {dma_ack_in, dma_early_ack_in} <= 8'($urandom);
        if (post) begin
            cfg_load <= 1'($urandom);
            cfg_low_match_mask <= $urandom;
        end
    endtask

    task summarize;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------
    // Every function with every alignment; range 1, 16 or 4G bytes
    // ----------
    initial begin
        void'($urandom(13053));
        for (int f = 0; f < 3; f++) begin
            for (int a = 0; a < 3; a++) begin
                @(posedge mclk);
                {resetn, cfg_load} <= 2'h0;
                msk = a == 0 ? 32'h0 : a == 1 ? 32'hf : 32'hffff_ffff;
                base = $urandom & ~msk;
                cfg_low_match_mask <= ~base | msk;
                cfg_high_match_mask <= base | msk;
                {cfg_function, cfg_align} <= {2'(f), 2'(a)};
                cfg_lane_base <= f == 2 ? 1'b0 : 1'($urandom);
                repeat (2) @(posedge mclk);
                resetn <= 1'b1;
                repeat (4) step(1'b0);
                cfg_load <= 1'b1;
                repeat (80) step(1'b1);
            end
        end
        summarize();
    end

    initial begin
        #1_000_000;
        err_total++;
        summarize();
    end
endmodule

// ### lane_decode.sv
// Combinational byte-lane decode for one selector
`timescale 1ns/1ps

module lane_decode
    import selector_pkg::*;
(
    input  wire logic [1:0] align,
    input  wire logic [1:0] size,
    input  wire logic [1:0] addr_lo,
    input  wire logic       lane_base,
    output logic      [1:0] lane_hit
);

    // ------------------------------------------------------------------
    // Lane mask of the transfer over all four lanes
    // ------------------------------------------------------------------
    logic [3:0] xfer_lanes;  // Lanes the transfer touches
    logic       size_ok;     // Size fits the configured alignment

    // Which lanes a transfer of this size and offset touches
    always_comb begin
        case (size)
            SIZE_WORD: xfer_lanes = 4'hf;
            SIZE_HALF: xfer_lanes = addr_lo[1] ? 4'hc : 4'h3;
            SIZE_BYTE: xfer_lanes = 4'h1 << addr_lo;
            default:   xfer_lanes = 4'h0;
        endcase
    end

    always_comb begin
        case (align)
            ALIGN_WORD: size_ok = (size == SIZE_WORD);
            ALIGN_HALF: size_ok = (size == SIZE_WORD) ||
                                  (size == SIZE_HALF);
            ALIGN_BYTE: size_ok = (size != 2'h3);
            default:    size_ok = 1'b0;
        endcase
    end

    // only lanes the transfer touches; bad size gives none
    always_comb begin
        if (!size_ok) begin
            lane_hit = 2'h0;
        end else if (lane_base) begin
            lane_hit = xfer_lanes[3:2];
        end else begin
            lane_hit = xfer_lanes[1:0];
        end
    end

endmodule

// ### selector_checker_asserts.sv
// Port-level concurrent checks for the bus address selector
`timescale 1ns/1ps

module selector_checker
    import selector_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              cfg_load,
    input wire logic [1:0]        cfg_function,
    input wire logic              bus_valid,
    input wire logic              bus_write,
    input wire logic [1:0]        bus_size,
    input wire logic [DATA_W-1:0] user_rdata,
    input wire logic [1:0]        read_decode_out,
    input wire logic [1:0]        write_decode_out,
    input wire logic [1:0]        chip_select_out,
    input wire logic [DATA_W-1:0] wdata_out,
    input wire logic [DATA_W-1:0] rdata_out,
    input wire logic [3:0]        dma_request_steer,
    input wire logic              cfg_loaded
);
    // ----------
    // Function seen at load time
    // ----------
    logic [1:0] fn_ff;   // Only the first load counts
    logic [1:0] nxt_fn;
    wire logic  any_dec;  // Any decode output lit
    assign any_dec = |{read_decode_out, write_decode_out,
                       chip_select_out};

    // Later loads are ignored by the block, so ignore them here too
    always_comb begin
        nxt_fn = fn_ff;
        if (cfg_load && !cfg_loaded) nxt_fn = cfg_function;
    end

    always_ff @(posedge mclk) begin
        fn_ff <= nxt_fn;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    no_load_idle_a: assert property (
        !cfg_loaded |=> !any_dec) else $error("decode before load");
    bad_size_a: assert property (
        bus_size == 2'h3 |=> !any_dec) else $error("decode on bad size");
    rdata_next_a: assert property (
        1'b1 |=> rdata_out == $past(user_rdata)) else $error("read data lag");
    write_cause_a: assert property (
        write_decode_out != 2'h0 |-> $past(bus_valid) && $past(bus_write))
        else $error("write decode without write");
    chip_dir_a: assert property (
        fn_ff == FUNC_CHIP && read_decode_out != 2'h0
        |-> chip_select_out == read_decode_out && !$past(bus_write))
        else $error("chip read direction wrong");
    word_lanes_a: assert property (
        bus_valid && bus_write && bus_size == SIZE_WORD
        |=> write_decode_out inside {2'h0, 2'h3}) else $error("word lanes");
    byte_lane_a: assert property (
        bus_valid && bus_size == SIZE_BYTE
        |=> (read_decode_out | write_decode_out | chip_select_out) != 2'h3)
        else $error("byte lit two lanes");
    byte_copy_a: assert property (
        write_decode_out != 2'h0 && $past(bus_size) == SIZE_BYTE
        |-> wdata_out == {4{wdata_out[7:0]}}) else $error("byte copy");
    half_copy_a: assert property (
        write_decode_out != 2'h0 && $past(bus_size) == SIZE_HALF
        |-> wdata_out[31:16] == wdata_out[15:0]) else $error("half copy");
    steer_onehot_a: assert property (
        $onehot0(dma_request_steer)) else $error("steer not one-hot");

    cover property (write_decode_out == 2'h3);
    cover property (chip_select_out != 2'h0 && read_decode_out != 2'h0);
    cover property (dma_request_steer != 4'h0);
endmodule

bind bus_address_selector selector_checker i_selector_checker (.*);

// ### selector_pkg.sv
// Shared constants and types for the bus address selector
package selector_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 32;           // Single linear space
    localparam int DATA_W     = 32;           // Read and write data width
    localparam int LANES      = 4;            // Byte lanes on the bus
    localparam int SEL_LANES  = 2;            // Lanes covered per selector

    // ------------------------------------------------------------------
    // Transfer size encoding on size input
    // ------------------------------------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // ------------------------------------------------------------------
    // Alignment setting encoding
    // ------------------------------------------------------------------
    localparam logic [1:0] ALIGN_BYTE = 2'h0;
    localparam logic [1:0] ALIGN_HALF = 2'h1;
    localparam logic [1:0] ALIGN_WORD = 2'h2;

    // ------------------------------------------------------------------
    // Function setting encoding
    // ------------------------------------------------------------------
    localparam logic [1:0] FUNC_SPLIT = 2'h0;   // Separate read/write
    localparam logic [1:0] FUNC_CHIP  = 2'h1;   // Chip select
    localparam logic [1:0] FUNC_DMA   = 2'h2;   // DMA control register

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    localparam logic [1:0]  LANE_RST  = 2'h0;
    localparam logic [1:0]  DMA_CH_RST = 2'h0;

    // Field positions inside the DMA control word
    localparam int DMA_EN_BIT  = 0;
    localparam int DMA_CH_LSB  = 1;
    localparam int DMA_CH_W    = 2;
    localparam int DMA_CHANNELS = 4;

    // Load sequencing states
    typedef enum logic [0:0] {
        ST_UNLOADED,
        ST_LOADED
    } load_state_type;

endpackage

// ### user_register_model.sv
// Behavioural user register on the far side of the selector
`timescale 1ns/1ps

module user_register_model
    import selector_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              cfg_lane_base,
    input  wire logic [1:0]        read_decode_out,
    input  wire logic [1:0]        write_decode_out,
    input  wire logic [DATA_W-1:0] wdata_out,
    output logic      [DATA_W-1:0] user_rdata
);
    // ----------
    // Storage and lane mapping
    // ----------
    logic [DATA_W-1:0] q = '0;   // Cleared so reads never show X
    logic [3:0]        wl;       // Write lanes on the full bus
    logic [3:0]        rl;       // Read lanes on the full bus

    // one selector serves one lane pair
    assign wl = cfg_lane_base ? {write_decode_out, 2'h0}
                              : {2'h0, write_decode_out};
    assign rl = cfg_lane_base ? {read_decode_out, 2'h0}
                              : {2'h0, read_decode_out};

    always @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (wl[i]) q[8*i +: 8] <= wdata_out[8*i +: 8];
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            user_rdata[8*i +: 8] = rl[i] ? q[8*i +: 8] : 8'h00;
        end
    end
endmodule
